/* File: rtl/rotate_alu.sv */
// opcode decode, operand addressing and rotate datapath
module rotate_alu
    import rotate_pkg::*;
#(
    parameter int BANK_W = 4
) (
    input  wire logic [15:0]         opcode,
    input  wire logic [BANK_W-1:0]   bank_sel,
    input  wire logic [7:0]          operand,
    output logic                     rot_right,
    output logic                     rot_left,
    output logic                     dest_file,
    output logic [BANK_W+7:0]        addr,
    output logic [7:0]               result,
    output logic                     neg,
    output logic                     zero
);
    always_comb begin
        rot_right = (opcode[OPC_HI:OPC_LO] == OPC_ROT_RIGHT);
        rot_left  = (opcode[OPC_HI:OPC_LO] == OPC_ROT_LEFT);
        dest_file = opcode[OPC_DEST_BIT];
        // any 8-bit file field is a legal address
        if (opcode[OPC_BANK_BIT]) begin
            addr = {bank_sel, opcode[OPC_BANK_BIT-1:0]};
        end else begin
            addr = {{BANK_W{1'b0}}, opcode[OPC_BANK_BIT-1:0]};
        end
        if (rot_left) begin
            result = {operand[6:0], operand[7]};
        end else begin
            result = {operand[0], operand[7:1]};
        end
        neg  = result[7];
        zero = (result == 8'h00);
    end
endmodule

/* File: rtl/rotate_core.sv */
// apb-reached rotate-without-carry unit with its file-register memory
// What this block does
// - right rotate moves each bit down, old bit 0 into bit 7, no carry
// - pattern 0100 01da plus file address is left rotate, bit 7 to bit 0
// - pattern 0100 00da plus file address is right rotate without carry
// - destination bit 0 writes the accumulator, file register unchanged
// - destination bit 1 writes result back into the same file register
// - bank bit 0 addresses the fixed access bank, ignoring bank select
// - bank bit 1 forms address from bank select and file address
// - every file address 0 to 255 is accepted, d and a single bits
//
// Added by the designer: the address map and the APB slave port.
module rotate_core
    import rotate_pkg::*;
#(
    parameter int BANK_W = 4
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr
);
    localparam int AW = BANK_W + 8;

    typedef struct packed {
        logic              pready;
        logic [31:0]       prdata;
        logic              pslverr;
        logic [7:0]        wreg;
        logic [BANK_W-1:0] bank;
        logic [7:0]        status;
        logic [AW-1:0]     ptr;
    } state_s;

    state_s          s_q;
    state_s          s_d;
    logic [7:0]      mem [0:(1<<AW)-1];
    logic            wr_en;
    logic            exec;
    logic            rot_right;
    logic            rot_left;
    logic            dest_file;
    logic [AW-1:0]   alu_addr;
    logic [7:0]      op_byte;
    logic [7:0]      result;
    logic            neg;
    logic            zero;
    logic            rot_ok;
    logic            mem_we;
    logic [AW-1:0]   mem_waddr;
    logic [7:0]      mem_wdata;

    // ****************************************************************
    // datapath
    // ****************************************************************
    assign op_byte = mem[alu_addr];

    rotate_alu #(
        .BANK_W    (BANK_W)
    ) u_alu (
        .opcode    (pwdata[15:0]),
        .bank_sel  (s_q.bank),
        .operand   (op_byte),
        .rot_right (rot_right),
        .rot_left  (rot_left),
        .dest_file (dest_file),
        .addr      (alu_addr),
        .result    (result),
        .neg       (neg),
        .zero      (zero)
    );

    assign wr_en  = psel & penable & s_q.pready & pwrite;
    assign exec   = wr_en & (paddr == OFS_OPCODE);
    assign rot_ok = rot_right | rot_left;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d         = s_q;
        s_d.pready  = psel & ~penable;
        mem_we      = 1'b0;
        mem_waddr   = s_q.ptr;
        mem_wdata   = pwdata[7:0];
        if (psel & ~penable) begin
            s_d.pslverr = 1'b0;
            s_d.prdata  = RDATA_RST;
            case (paddr)
                OFS_OPCODE: begin
                    s_d.prdata = RDATA_RST;
                end
                OFS_BANK_SEL: begin
                    s_d.prdata[BANK_W-1:0] = s_q.bank;
                end
                OFS_WREG: begin
                    s_d.prdata[7:0] = s_q.wreg;
                end
                OFS_STATUS: begin
                    s_d.prdata[7:0] = s_q.status;
                end
                OFS_MEM_PTR: begin
                    s_d.prdata[AW-1:0] = s_q.ptr;
                end
                OFS_MEM_DATA: begin
                    s_d.prdata[7:0] = mem[s_q.ptr];
                end
                default: begin
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
        if (wr_en) begin
            case (paddr)
                OFS_OPCODE: begin
                    // executes in the same edge that takes the write
                    s_d.status[ST_BAD] = ~rot_ok;
                    if (rot_ok) begin
                        s_d.status[ST_N] = neg;
                        s_d.status[ST_Z] = zero;
                        if (dest_file) begin
                            mem_we    = 1'b1;
                            mem_waddr = alu_addr;
                            mem_wdata = result;
                        end else begin
                            s_d.wreg = result;
                        end
                    end
                end
                OFS_BANK_SEL: begin
                    s_d.bank = pwdata[BANK_W-1:0];
                end
                OFS_WREG: begin
                    s_d.wreg = pwdata[7:0];
                end
                OFS_STATUS: begin
                    s_d.status = pwdata[7:0];
                end
                OFS_MEM_PTR: begin
                    s_d.ptr = pwdata[AW-1:0];
                end
                OFS_MEM_DATA: begin
                    mem_we = 1'b1;
                end
                default: begin
                    mem_we = 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.pready  <= 1'b0;
            s_q.prdata  <= RDATA_RST;
            s_q.pslverr <= 1'b0;
            s_q.wreg    <= WREG_RST;
            s_q.bank    <= '0;
            s_q.status  <= STATUS_RST;
            s_q.ptr     <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    assign pready  = s_q.pready;
    assign prdata  = s_q.prdata;
    assign pslverr = s_q.pslverr;

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [7:0] rr_ref;
    logic [7:0] rl_ref;
    assign rr_ref = {op_byte[0], op_byte[7:1]};
    assign rl_ref = {op_byte[6:0], op_byte[7]};

    property p_rot_right;
        @(posedge pclk) disable iff (!presetn)
        exec && rot_right && !dest_file |=> s_q.wreg == $past(rr_ref);
    endproperty
    a_rot_right: assert property (p_rot_right)
        else $error("right rotate result wrong");

    property p_rot_left;
        @(posedge pclk) disable iff (!presetn)
        exec && rot_left && !dest_file |=> s_q.wreg == $past(rl_ref);
    endproperty
    a_rot_left: assert property (p_rot_left)
        else $error("left rotate result wrong");

    property p_right_file;
        @(posedge pclk) disable iff (!presetn)
        exec && pwdata[OPC_HI:OPC_LO] == OPC_ROT_RIGHT && dest_file
        |=> mem[$past(alu_addr)] == $past(rr_ref);
    endproperty
    a_right_file: assert property (p_right_file)
        else $error("right rotate pattern not executed");

    property p_dest_w;
        @(posedge pclk) disable iff (!presetn)
        exec && rot_ok && !dest_file
        |=> mem[$past(alu_addr)] == $past(op_byte);
    endproperty
    a_dest_w: assert property (p_dest_w)
        else $error("file register changed on accumulator result");

    property p_dest_f;
        @(posedge pclk) disable iff (!presetn)
        exec && rot_left && dest_file
        |=> mem[$past(alu_addr)] == $past(rl_ref)
            && $stable(s_q.wreg);
    endproperty
    a_dest_f: assert property (p_dest_f)
        else $error("file writeback wrong");

    property p_access_bank;
        @(posedge pclk) disable iff (!presetn)
        exec && !pwdata[OPC_BANK_BIT]
        |-> alu_addr == {{BANK_W{1'b0}}, pwdata[7:0]};
    endproperty
    a_access_bank: assert property (p_access_bank)
        else $error("access bank not used");

    property p_banked;
        @(posedge pclk) disable iff (!presetn)
        exec && pwdata[OPC_BANK_BIT] |-> alu_addr[AW-1:8] == s_q.bank;
    endproperty
    a_banked: assert property (p_banked)
        else $error("bank select not applied");

    property p_any_addr;
        @(posedge pclk) disable iff (!presetn)
        exec && (pwdata[OPC_HI:OPC_LO] == OPC_ROT_RIGHT
                 || pwdata[OPC_HI:OPC_LO] == OPC_ROT_LEFT)
        |=> !s_q.status[ST_BAD];
    endproperty
    a_any_addr: assert property (p_any_addr)
        else $error("valid rotate refused");

    property p_flags;
        @(posedge pclk) disable iff (!presetn)
        exec && rot_ok |=> s_q.status[ST_C] == $past(s_q.status[ST_C])
            && s_q.status[ST_Z] == ($past(result) == 8'h00)
            && s_q.status[ST_N] == $past(result[7]);
    endproperty
    a_flags: assert property (p_flags)
        else $error("status flags wrong after rotate");

    c_left_w:  cover property (@(posedge pclk) exec && rot_left && !dest_file);
    c_right_f: cover property (@(posedge pclk) exec && rot_right && dest_file);
    c_zero:    cover property (@(posedge pclk) exec && rot_ok && zero);
endmodule

/* File: shared/rotate_pkg.sv */
// constants shared by the rotate-without-carry execution unit
package rotate_pkg;
    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [11:0] OFS_OPCODE   = 12'h000;
    localparam logic [11:0] OFS_BANK_SEL = 12'h004;
    localparam logic [11:0] OFS_WREG     = 12'h008;
    localparam logic [11:0] OFS_STATUS   = 12'h00c;
    localparam logic [11:0] OFS_MEM_PTR  = 12'h010;
    localparam logic [11:0] OFS_MEM_DATA = 12'h014;

    // ****************************************************************
    // opcode layout
    // ****************************************************************
    localparam int          OPC_HI        = 15;
    localparam int          OPC_LO        = 10;
    localparam int          OPC_DEST_BIT  = 9;
    localparam int          OPC_BANK_BIT  = 8;
    localparam logic [5:0]  OPC_ROT_RIGHT = 6'h10;
    localparam logic [5:0]  OPC_ROT_LEFT  = 6'h11;

    // ****************************************************************
    // status layout and reset values
    // ****************************************************************
    localparam int          ST_C   = 0;
    localparam int          ST_Z   = 2;
    localparam int          ST_N   = 4;
    localparam int          ST_BAD = 7;
    localparam logic [7:0]  STATUS_RST = 8'h00;
    localparam logic [7:0]  WREG_RST   = 8'h00;
    localparam logic [31:0] RDATA_RST  = 32'h0000_0000;
endpackage

/* File: testbench/core_fetch_model.sv */
// far-side model: core fetch issuing apb transfers to the unit
module core_fetch_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [11:0] addr,
    input  wire logic [31:0] wdata,
    output logic             done,
    output logic [32:0]      rsp,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    // setup, access until pready, then release with scrambled lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            pwrite  <= 1'b0;
            paddr   <= 12'h000;
            pwdata  <= 32'h0000_0000;
            done    <= 1'b0;
            rsp     <= 33'h0;
        end else begin
            done <= 1'b0;
            if (!psel && go && !done) begin
                psel   <= 1'b1;
                pwrite <= wr;
                paddr  <= addr;
                pwdata <= wdata;
            end else if (psel && !penable) begin
                penable <= 1'b1;
            end else if (psel && pready) begin
                psel    <= 1'b0;
                penable <= 1'b0;
                done    <= 1'b1;
                rsp     <= {pslverr, prdata};
                paddr   <= ~paddr;
                pwdata  <= ~pwdata;
            end
        end
    end
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the rotate-without-carry unit
module tb_top import rotate_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, go, wr, done;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] addr, paddr;
    logic [31:0] wdata, pwdata, prdata;
    logic [32:0] rsp;
    logic [32:0] exp_q[$];
    int          fails = 0;
    int          n_tests = 0;

    core_fetch_model host_u (.pclk, .presetn, .go, .wr, .addr, .wdata,
        .done, .rsp, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr);
    rotate_core #(.BANK_W(4)) dut_u (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);

    always #4 pclk = ~pclk;

    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        go    <= 1'b1;
        wr    <= w;
        addr  <= a;
        wdata <= d;
        do begin
            @(posedge pclk);
            n++;
        end while (done !== 1'b1 && n < 20);
        if (done !== 1'b1) fails++;
        go <= 1'b0;
    endtask

    task automatic wrr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask

    task automatic chk(input logic [32:0] e, input logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // ****************************************************************
    // read results against the oldest note
    // ****************************************************************
    always @(posedge pclk) begin
        if (done === 1'b1 && wr === 1'b0) begin
            if (exp_q.size() == 0) fails++;
            else chk(exp_q.pop_front(), rsp);
        end
    end

    task summarize;
        if (exp_q.size() != 0) fails++;
        $display("checks=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #400000;
        fails++;
        summarize();
    end

    initial begin
        logic [7:0]  v, w, s, r, f, es;
        logic [15:0] op;
        logic [3:0]  b;
        logic        d, a, lf;
        logic [11:0] ea, oa;
        pclk = 0;
        presetn = 0;
        go = 0;
        wr = 0;
        addr = 0;
        wdata = 0;
        void'($urandom(32'h97a4ff6a));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // register reset values
        rd(OFS_WREG, 33'h0);
        rd(OFS_STATUS, 33'h0);
        rd(OFS_BANK_SEL, 33'h0);
        for (int i = 0; i < 40; i++) begin
            v = (i == 0) ? 8'h00 : 8'($urandom);
            f = (i == 1) ? 8'hff : (i == 2) ? 8'h00 : 8'($urandom);
            {d, a, lf} = (i < 3) ? 3'(i + 4) : 3'($urandom);
            b = (i < 3) ? 4'h5 : 4'($urandom);
            w = 8'($urandom);
            s = 8'($urandom) & 8'h7f;
            ea = a ? {b, f} : {4'h0, f};
            oa = a ? {4'h0, f} : {b, f};
            r = lf ? {v[6:0], v[7]} : {v[0], v[7:1]};
            wrr(OFS_BANK_SEL, {4'h0, b});
            if (oa != ea) begin
                wrr(OFS_MEM_PTR, oa[7:0]);
                xfer(1'b1, OFS_MEM_PTR, {20'h0, oa});
                wrr(OFS_MEM_DATA, ~v);
            end
            xfer(1'b1, OFS_MEM_PTR, {20'h0, ea});
            wrr(OFS_MEM_DATA, v);
            wrr(OFS_WREG, w);
            wrr(OFS_STATUS, s);
            op = {5'h08, lf, d, a, f};
            es = {s[7:5], r[7], s[3], r == 8'h00, s[1:0]};
            xfer(1'b1, OFS_OPCODE, {16'h0, op});
            rd(OFS_WREG, {25'h0, d ? w : r});
            rd(OFS_MEM_DATA, {25'h0, d ? r : v});
            rd(OFS_STATUS, {25'h0, es});
            if (oa != ea) begin
                xfer(1'b1, OFS_MEM_PTR, {20'h0, oa});
                rd(OFS_MEM_DATA, {25'h0, ~v});
            end
        end
        // neighbouring through-carry pattern must not execute
        wrr(OFS_STATUS, 8'h00);
        xfer(1'b1, OFS_OPCODE, 32'h0000_3400);
        rd(OFS_STATUS, 33'h80);
        // unmapped offset answers with an error and zero
        rd(12'h018, {1'b1, 32'h0});
        repeat (4) @(posedge pclk);
        summarize();
    end
endmodule
